// ===== design/boiler_ignition_sequencer.sv
`timescale 1ns/10ps
`include "ignition_defs.svh"
module boiler_ignition_sequencer
  import ignition_pkg::*;
#(
  parameter int unsigned TICK_CLKS = `ONE_SEC_NS / `CLK_PERIOD_NS,
  parameter int unsigned HOLD_CLKS = `HOLD_ENTRY_S * (`ONE_SEC_NS / `CLK_PERIOD_NS)
) (
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  input  wire logic               heat_call_pin,
  input  wire logic               pressure_sw_pin,
  input  wire logic               flame_sense_pin,
  input  wire logic               btn_up_pin,
  input  wire logic               btn_down_pin,
  input  wire logic               btn_item_pin,
  input  wire logic               lockout_clear_pin,
  input  wire logic signed [8:0]  water_temp,
  input  wire logic signed [8:0]  operating_target,
  input  wire logic [7:0]         ionization_level,
  input  wire logic               outdoor_valid,
  input  wire logic               nv_lock_in,
  output drive_t                  burner,
  output logic [4:0]              phase_readout,
  output logic [7:0]              error_code,
  output disp_t                   display,
  output logic                    adjust_mode,
  output logic [8:0]              upper_temp_cutout,
  output logic [8:0]              cutout_hysteresis,
  output logic [8:0]              outdoor_design_max,
  output logic [8:0]              outdoor_design_min,
  output logic [8:0]              purge_floor_temp,
  output logic [8:0]              purge_time_cap
);
  localparam par_set_t PAR_RST = {9'h000, 9'h000, `PCAP_DEF, `PFLOOR_DEF, `WMIN_DEF,
                                  `ODMIN_DEF, `ODMAX_DEF, `OVRUN_DEF, `HYST_DEF, `CUTOUT_DEF};

  core_t       st_ff;
  core_t       nxt_st;
  logic [6:0]  pins;
  logic        tick;
  logic        heat;
  logic        ps;
  logic        flm;

  pin_sync #(.W(7)) u_sync (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .pin_raw   ({lockout_clear_pin, btn_item_pin, btn_down_pin, btn_up_pin,
                 flame_sense_pin, pressure_sw_pin, heat_call_pin}),
    .pin_clean (pins)
  );

  assign tick = (st_ff.tick_cnt == 32'(TICK_CLKS - 1));
  assign heat = pins[`PIN_HEAT];
  assign ps   = pins[`PIN_PS];
  assign flm  = pins[`PIN_FLAME];

  function automatic logic signed [8:0] par_min(input logic [3:0] i);
    case (i)
      `P_CUTOUT: par_min = `CUTOUT_MIN;
      `P_HYST:   par_min = `HYST_MIN;
      `P_ODMAX:  par_min = `ODMAX_MIN;
      `P_ODMIN:  par_min = `ODMIN_MIN;
      `P_WMIN:   par_min = `WMIN_MIN;
      `P_PFLOOR: par_min = `PFLOOR_OFF;
      `P_PCAP:   par_min = `PCAP_MIN;
      default:   par_min = 9'h000;
    endcase
  endfunction

  function automatic logic signed [8:0] par_max(input logic [3:0] i);
    case (i)
      `P_CUTOUT: par_max = `CUTOUT_MAX;
      `P_HYST:   par_max = `HYST_MAX;
      `P_OVRUN:  par_max = `OVRUN_MAX;
      `P_ODMAX:  par_max = `ODMAX_MAX;
      `P_ODMIN:  par_max = `ODMIN_MAX;
      `P_WMIN:   par_max = `WMIN_MAX;
      `P_PFLOOR: par_max = `PFLOOR_MAX;
      `P_PCAP:   par_max = `PCAP_MAX;
      default:   par_max = 9'h001;
    endcase
  endfunction

  // fahrenheit to celsius; hysteresis is a span, so no offset there
  function automatic logic signed [11:0] to_c(input logic signed [11:0] f,
                                              input logic span);
    to_c = span ? (f * 12'sh005) / 12'sh009 : ((f - 12'sh020) * 12'sh005) / 12'sh009;
  endfunction

  function automatic logic signed [11:0] sx(input logic [8:0] v);
    sx = {{3{v[8]}}, v};
  endfunction

  always_comb
  begin : next_state
    seq_t       nseq;
    logic [2:0] prs;
    logic [2:0] rel;
    logic       all3;
    logic       anyb;
    logic       lclr;
    logic [3:0] ai;
    logic signed [8:0]  pv;
    logic signed [11:0] v;
    logic       cel;
    nseq = st_ff.seq;
    prs  = pins[5:3] & ~st_ff.btn_prev;
    rel  = ~pins[5:3] & st_ff.btn_prev;
    all3 = &pins[5:3];
    anyb = |pins[5:3];
    lclr = pins[`PIN_LCLR] | st_ff.par[`P_LCLR][0];
    ai   = st_ff.aitem;
    pv   = $signed(st_ff.par[ai]);
    v    = 12'sh000;
    cel  = st_ff.par[`P_UNIT][0];
    nxt_st = st_ff;
    nxt_st.tick_cnt = tick ? 32'h0 : st_ff.tick_cnt + 32'h1;
    nxt_st.booted   = 1'b1;
    nxt_st.btn_prev = pins[5:3];
    nxt_st.par[`P_LCLR] = 9'h000; // one-shot request, consumed this cycle

    // cutout with hysteresis against chattering on the limit
    if (water_temp > $signed(st_ff.par[`P_CUTOUT]))
      nxt_st.hot = 1'b1;
    else if ($signed({water_temp[8], water_temp}) + $signed({1'b0, st_ff.par[`P_HYST]})
             < $signed({1'b0, st_ff.par[`P_CUTOUT]}))
      nxt_st.hot = 1'b0;

    // button-gated entry into adjust mode
    nxt_st.hold_cnt = all3 ? st_ff.hold_cnt + 32'h1 : 32'h0;
    if (!st_ff.adj && all3 && st_ff.hold_cnt == 32'(HOLD_CLKS - 1))
    begin
      nxt_st.adj    = 1'b1;
      nxt_st.armed  = 1'b0;
      nxt_st.aitem  = `P_CUTOUT;
      nxt_st.idle_s = 6'h00;
    end
    else if (st_ff.adj)
    begin
      // buttons still held from entry must be released before they count
      if (!anyb)
        nxt_st.armed = 1'b1;
      if (anyb)
        nxt_st.idle_s = 6'h00;
      else if (tick && st_ff.idle_s == 6'(`ADJ_IDLE_S - 1))
        nxt_st.adj = 1'b0;
      else if (tick)
        nxt_st.idle_s = st_ff.idle_s + 6'h01;
      if (st_ff.armed && rel[2])
      begin
        nxt_st.aitem = (ai == `P_UNIT) ? `P_CUTOUT : ai + 4'h1;
        // purge settings only when the outdoor reading is bad
        if (outdoor_valid && ai == `P_WMIN)
          nxt_st.aitem = `P_LCLR;
      end
      else if (st_ff.armed && prs[0] && pv < par_max(ai))
        nxt_st.par[ai] = pv + 9'sh001;
      else if (st_ff.armed && prs[1] && pv > par_min(ai))
        nxt_st.par[ai] = pv - 9'sh001;
    end
    else if (rel[2] && !all3)
      nxt_st.ritem = (st_ff.ritem == RD_ERROR) ? RD_PHASE
                   : read_item_t'(st_ff.ritem + 4'h1);

    // burner sequence; later checks take priority
    case (st_ff.seq)
      SQ_IDLE:
      begin
        if (heat)
          nseq = st_ff.hot ? SQ_CIRC : SQ_PS_OPEN;
      end
      SQ_CIRC:
      begin
        if (!st_ff.hot)
          nseq = SQ_PS_OPEN;
        if (!heat)
          nseq = SQ_IDLE;
      end
      SQ_PS_OPEN:
      begin
        if (tick && st_ff.secs == 12'(`PS_WAIT_S - 1))
          nseq = SQ_PS_FAIL_CLOSED;
        if (!ps)
          nseq = SQ_PS_CLOSE;
        if (!heat)
          nseq = SQ_IDLE;
      end
      SQ_PS_FAIL_CLOSED:
      begin
        if (!ps)
          nseq = SQ_PS_CLOSE;
        if (!heat)
          nseq = SQ_IDLE;
      end
      SQ_PS_CLOSE, SQ_PS_FAIL_OPEN:
      begin
        if (st_ff.seq == SQ_PS_CLOSE && tick && st_ff.secs == 12'(`PS_WAIT_S - 1))
          nseq = SQ_PS_FAIL_OPEN;
        if (ps)
          nseq = SQ_PREPURGE;
        if (!heat)
          nseq = SQ_IDLE;
      end
      SQ_PREPURGE:
      begin
        if (tick && st_ff.secs == 12'(`PREPURGE_S - 1))
          nseq = SQ_SPARK;
        if (!heat || st_ff.hot)
          nseq = SQ_IDLE;
        if (!ps)
          nseq = SQ_RELAY_DELAY;
      end
      SQ_SPARK:
      begin
        if (tick && st_ff.secs == 12'(`SPARK_S - 1))
        begin
          if (flm)
            nseq = SQ_PROVE;
          else if (st_ff.tries == `TRIES_MAX)
            nseq = SQ_SOFT_LOCK;
          else
          begin
            nseq = SQ_INTERPURGE;
            nxt_st.tries = st_ff.tries + 2'h1;
          end
        end
        if (st_ff.hot)
          nseq = SQ_INTERPURGE;
        if (!heat)
          nseq = SQ_IDLE;
        if (!ps)
          nseq = SQ_RELAY_DELAY;
      end
      SQ_PROVE, SQ_RUN:
      begin
        if (st_ff.seq == SQ_PROVE && tick && st_ff.secs == 12'(`PROVE_S - 1))
        begin
          nseq = SQ_RUN;
          nxt_st.tries   = 2'h0;
          nxt_st.firings = st_ff.firings + 16'h0001;
        end
        if (!heat)
          nseq = SQ_IDLE;
        if (st_ff.hot || !flm)
          nseq = SQ_INTERPURGE;
      end
      SQ_INTERPURGE:
      begin
        if (tick && st_ff.secs == 12'(`INTERPURGE_S - 1))
          nseq = SQ_PREPURGE;
        if (!heat)
          nseq = SQ_IDLE;
      end
      SQ_RELAY_DELAY:
      begin
        if (tick && st_ff.secs == 12'(`RELAY_DELAY_S - 1))
          nseq = SQ_PS_FAIL_OPEN;
      end
      SQ_SOFT_LOCK:
      begin
        if (lclr || (tick && st_ff.secs == 12'(`SOFT_LOCK_S - 1)))
          nseq = SQ_IDLE;
      end
      SQ_HARD_LOCK:
      begin
        if (lclr)
          nseq = SQ_IDLE;
      end
      default:
        nseq = SQ_IDLE;
    endcase

    // stored lockout is restored on the first cycle after reset
    if (!st_ff.booted && nv_lock_in)
      nseq = SQ_HARD_LOCK;

    nxt_st.seq = nseq;
    if (nseq != st_ff.seq)
      nxt_st.secs = (nseq == SQ_PREPURGE && st_ff.seq == SQ_INTERPURGE)
                  ? 12'(`PREPURGE_S - `RELAY_TEST_S) : 12'h000;
    else if (tick)
      nxt_st.secs = st_ff.secs + 12'h001;
    if (nseq == SQ_IDLE && st_ff.seq inside {SQ_SOFT_LOCK, SQ_HARD_LOCK})
    begin
      nxt_st.tries = 2'h0;
      nxt_st.err   = 8'h00;
    end
    if (nseq == SQ_SOFT_LOCK)
      nxt_st.err = `ERR_SOFT;

    // drivers follow the next state so they line up with it
    nxt_st.drv.inducer = nseq inside {SQ_PS_CLOSE, SQ_PS_FAIL_OPEN, SQ_PREPURGE,
                                      SQ_SPARK, SQ_PROVE, SQ_RUN, SQ_INTERPURGE};
    nxt_st.drv.gas     = nseq inside {SQ_SPARK, SQ_PROVE, SQ_RUN};
    nxt_st.drv.igniter = (nseq == SQ_SPARK);
    nxt_st.drv.relay_test = (nseq == SQ_PREPURGE)
                          && (nxt_st.secs >= 12'(`PREPURGE_S - `RELAY_TEST_S));
    nxt_st.drv.alarm   = nseq inside {SQ_PS_FAIL_CLOSED, SQ_PS_FAIL_OPEN,
                                      SQ_SOFT_LOCK, SQ_HARD_LOCK};
    nxt_st.drv.nv_lock = (nseq == SQ_HARD_LOCK);

    // overrun reloads while the call stands outside soft or hard lockout, counts down otherwise
    if (heat && !(nseq inside {SQ_SOFT_LOCK, SQ_HARD_LOCK}))
      nxt_st.ovr_left = st_ff.par[`P_OVRUN][6:0];
    else if (tick && st_ff.ovr_left != 7'h00)
      nxt_st.ovr_left = st_ff.ovr_left - 7'h01;
    nxt_st.drv.circ = (nxt_st.ovr_left != 7'h00);

    case (nseq)
      SQ_IDLE, SQ_CIRC:       nxt_st.code = `PH_IDLE;
      SQ_PS_OPEN:             nxt_st.code = `PH_PSOPN;
      SQ_PS_CLOSE:            nxt_st.code = `PH_PSCLS;
      SQ_RELAY_DELAY:         nxt_st.code = `PH_PSCLS;
      SQ_PREPURGE:            nxt_st.code = `PH_PURGE;
      SQ_SPARK:               nxt_st.code = `PH_SPARK;
      SQ_PROVE:               nxt_st.code = `PH_PROVE;
      SQ_RUN:                 nxt_st.code = `PH_RUN;
      SQ_INTERPURGE:          nxt_st.code = `PH_INTER;
      SQ_PS_FAIL_CLOSED:      nxt_st.code = `PH_PSFC;
      SQ_PS_FAIL_OPEN:        nxt_st.code = `PH_PSFO;
      SQ_SOFT_LOCK:           nxt_st.code = `PH_SOFT;
      default:                nxt_st.code = `PH_HARD;
    endcase

    // run time in whole hours
    if (st_ff.seq == SQ_RUN && tick)
    begin
      nxt_st.hr_secs = (st_ff.hr_secs == 12'(`HOUR_S - 1)) ? 12'h000 : st_ff.hr_secs + 12'h001;
      if (st_ff.hr_secs == 12'(`HOUR_S - 1))
        nxt_st.hours = st_ff.hours + 16'h0001;
    end

    // display: label, value, unit, one screen per second
    if (tick)
      nxt_st.disp.screen = (st_ff.disp.screen == 2'h2) ? 2'h0 : st_ff.disp.screen + 2'h1;
    nxt_st.disp.unit = cel ? UN_C : UN_F;
    if (st_ff.adj)
    begin
      nxt_st.disp.label = {1'b1, ai};
      v = sx(st_ff.par[ai]);
      if (ai == `P_OVRUN)
        nxt_st.disp.unit = UN_SEC;
      else if (ai == `P_PCAP)
        nxt_st.disp.unit = UN_MIN;
      else if (ai >= `P_LCLR)
        nxt_st.disp.unit = UN_NONE;
      else if (cel && !(ai == `P_PFLOOR && st_ff.par[ai] == `PFLOOR_OFF))
        v = to_c(v, ai == `P_HYST);
    end
    else
    begin
      nxt_st.disp.label = {1'b0, st_ff.ritem};
      case (st_ff.ritem)
        RD_PHASE:   v = {7'h00, st_ff.code};
        RD_WATER:   v = sx(water_temp);
        RD_TARGET:  v = sx(operating_target);
        RD_CUTOUT:  v = sx(st_ff.par[`P_CUTOUT]);
        RD_HYST:    v = sx(st_ff.par[`P_HYST]);
        RD_IONIZ:   v = {4'h0, ionization_level};
        RD_HOURS:   v = st_ff.hours[11:0];
        RD_FIRINGS: v = st_ff.firings[11:0];
        default:    v = {4'h0, st_ff.err};
      endcase
      if (cel && st_ff.ritem inside {RD_WATER, RD_TARGET, RD_CUTOUT, RD_HYST})
        v = to_c(v, st_ff.ritem == RD_HYST);
      else if (!(st_ff.ritem inside {RD_WATER, RD_TARGET, RD_CUTOUT, RD_HYST}))
        nxt_st.disp.unit = UN_NONE;
    end
    nxt_st.disp.value = v;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      st_ff     <= '0;
      st_ff.par <= PAR_RST;
    end
    else
      st_ff <= nxt_st;
  end

  assign burner             = st_ff.drv;
  assign phase_readout      = st_ff.code;
  assign error_code         = st_ff.err;
  assign display            = st_ff.disp;
  assign adjust_mode        = st_ff.adj;
  assign upper_temp_cutout  = st_ff.par[`P_CUTOUT];
  assign cutout_hysteresis  = st_ff.par[`P_HYST];
  assign outdoor_design_max = st_ff.par[`P_ODMAX];
  assign outdoor_design_min = st_ff.par[`P_ODMIN];
  assign purge_floor_temp   = st_ff.par[`P_PFLOOR];
  assign purge_time_cap     = st_ff.par[`P_PCAP];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // any button seen by the sequencer, for the quiet-exit check
  logic anyb_q;
  assign anyb_q = |pins[5:3];

  sequence s_ps_open_expired;
    st_ff.seq == SQ_PS_OPEN && tick && st_ff.secs == 12'(`PS_WAIT_S - 1) && ps && heat;
  endsequence
  sequence s_prove_done;
    st_ff.seq == SQ_PROVE && tick && st_ff.secs == 12'(`PROVE_S - 1) && flm && heat
      && !st_ff.hot;
  endsequence
  sequence s_adj_quiet_end;
    st_ff.adj && tick && st_ff.idle_s == 6'(`ADJ_IDLE_S - 1) && !anyb_q;
  endsequence

  AST_CUTOUT_RANGE: assert property ($signed(st_ff.par[`P_CUTOUT]) >= 9'sh050
    && $signed(st_ff.par[`P_CUTOUT]) <= 9'sh0BE) else $error("cutout out of range");
  AST_HYST_RANGE: assert property (st_ff.par[`P_HYST] >= 9'h00A
    && st_ff.par[`P_HYST] <= 9'h01E) else $error("hysteresis out of range");
  AST_ADJ_TIMEOUT: assert property (s_adj_quiet_end |=> !adjust_mode)
    else $error("adjust mode did not time out");
  // the cycle straight out of reset still shows the cleared code, so skip it
  AST_IDLE_CODE: assert property (st_ff.booted && st_ff.seq == SQ_IDLE
    |-> phase_readout == 5'h01 && !burner.gas && !burner.inducer)
    else $error("idle not standby");
  AST_PS_OPEN_TMO: assert property (s_ps_open_expired |=> st_ff.seq == SQ_PS_FAIL_CLOSED
    ##0 phase_readout == 5'h0B) else $error("state 2 timeout missed");
  AST_SPARK_GAS: assert property (burner.igniter |-> burner.gas
    && phase_readout == 5'h06) else $error("spark without gas");
  AST_RELAY_WINDOW: assert property (burner.relay_test |-> st_ff.seq == SQ_PREPURGE
    && st_ff.secs >= 12'h01C) else $error("relay test outside last 2 s");
  AST_PROVE_RUN: assert property (s_prove_done |=> st_ff.seq == SQ_RUN ##0 burner.gas)
    else $error("flame proving did not reach run");
  AST_FLAME_LOSS: assert property (st_ff.seq == SQ_RUN && !flm |=> st_ff.seq == SQ_INTERPURGE
    ##0 !burner.gas) else $error("flame loss not handled");
  AST_SOFT_ERR: assert property (st_ff.seq == SQ_SOFT_LOCK |-> error_code == 8'h3E
    && !burner.gas) else $error("soft lockout without error 62");
  AST_PS_NO_LOCK: assert property (phase_readout inside {5'h0B, 5'h0C} |-> burner.alarm
    && !burner.nv_lock) else $error("pressure failure alarm wrong");
endmodule // boiler_ignition_sequencer

// ===== inc/ignition_defs.svh
`ifndef IGNITION_DEFS_SVH
`define IGNITION_DEFS_SVH

// clock and one-second tick
`define CLK_PERIOD_NS 10
`define ONE_SEC_NS    1000000000

// times in seconds
`define HOLD_ENTRY_S  3
`define ADJ_IDLE_S    60
`define PS_WAIT_S     60
`define RELAY_DELAY_S 3
`define PREPURGE_S    30
`define RELAY_TEST_S  2
`define SPARK_S       13
`define PROVE_S       2
`define INTERPURGE_S  30
`define SOFT_LOCK_S   3600
`define HOUR_S        3600

// positions in the synchronised pin vector
`define PIN_HEAT   0
`define PIN_PS     1
`define PIN_FLAME  2
`define PIN_UP     3
`define PIN_DOWN   4
`define PIN_ITEM   5
`define PIN_LCLR   6

// positions in the parameter set
`define P_CUTOUT 4'h0
`define P_HYST   4'h1
`define P_OVRUN  4'h2
`define P_ODMAX  4'h3
`define P_ODMIN  4'h4
`define P_WMIN   4'h5
`define P_PFLOOR 4'h6
`define P_PCAP   4'h7
`define P_LCLR   4'h8
`define P_UNIT   4'h9

// defaults, minima and maxima (9-bit two's complement)
`define CUTOUT_DEF 9'h0B4
`define CUTOUT_MIN 9'h050
`define CUTOUT_MAX 9'h0BE
`define HYST_DEF   9'h00F
`define HYST_MIN   9'h00A
`define HYST_MAX   9'h01E
`define OVRUN_DEF  9'h03C
`define OVRUN_MAX  9'h078
`define ODMAX_DEF  9'h037
`define ODMAX_MIN  9'h028
`define ODMAX_MAX  9'h046
`define ODMIN_DEF  9'h000
`define ODMIN_MIN  9'h1D8
`define ODMIN_MAX  9'h028
`define WMIN_DEF   9'h08C
`define WMIN_MIN   9'h082
`define WMIN_MAX   9'h096
`define PFLOOR_DEF 9'h08C
`define PFLOOR_OFF 9'h077
`define PFLOOR_MAX 9'h0A0
`define PCAP_DEF   9'h002
`define PCAP_MIN   9'h001
`define PCAP_MAX   9'h00A

// readout codes
`define PH_IDLE  5'h01
`define PH_PSOPN 5'h02
`define PH_PSCLS 5'h03
`define PH_PURGE 5'h04
`define PH_SPARK 5'h06
`define PH_PROVE 5'h07
`define PH_RUN   5'h08
`define PH_INTER 5'h0A
`define PH_PSFC  5'h0B
`define PH_PSFO  5'h0C
`define PH_SOFT  5'h0D
`define PH_HARD  5'h0E
`define ERR_SOFT 8'h3E
`define TRIES_MAX 2'h2

`endif

// ===== inc/ignition_pkg.sv
package ignition_pkg;

  localparam int NPAR = 10;

  typedef enum logic [3:0] {
    SQ_IDLE, SQ_CIRC, SQ_PS_OPEN, SQ_PS_FAIL_CLOSED, SQ_PS_CLOSE, SQ_PS_FAIL_OPEN,
    SQ_PREPURGE, SQ_SPARK, SQ_PROVE, SQ_RUN, SQ_INTERPURGE, SQ_RELAY_DELAY,
    SQ_SOFT_LOCK, SQ_HARD_LOCK
  } seq_t;

  typedef enum logic [3:0] {
    RD_PHASE, RD_WATER, RD_TARGET, RD_CUTOUT, RD_HYST, RD_IONIZ, RD_HOURS,
    RD_FIRINGS, RD_ERROR
  } read_item_t;

  typedef enum logic [2:0] {UN_F, UN_C, UN_SEC, UN_MIN, UN_NONE} disp_unit_t;

  typedef logic [NPAR-1:0][8:0] par_set_t;

  // burner driver group
  typedef struct packed {
    logic inducer;
    logic gas;
    logic igniter;
    logic circ;
    logic relay_test;
    logic alarm;
    logic nv_lock;
  } drive_t;

  // three-screen display group
  typedef struct packed {
    logic [1:0]        screen;
    logic [4:0]        label;
    logic signed [11:0] value;
    disp_unit_t        unit;
  } disp_t;

  typedef struct packed {
    seq_t        seq;
    logic [11:0] secs;
    logic [31:0] tick_cnt;
    logic [1:0]  tries;
    logic        hot;
    logic [6:0]  ovr_left;
    logic        booted;
    logic        adj;
    logic        armed;
    logic [31:0] hold_cnt;
    logic [5:0]  idle_s;
    read_item_t  ritem;
    logic [3:0]  aitem;
    logic [2:0]  btn_prev;
    par_set_t    par;
    logic [11:0] hr_secs;
    logic [15:0] hours;
    logic [15:0] firings;
    drive_t      drv;
    logic [4:0]  code;
    logic [7:0]  err;
    disp_t       disp;
  } core_t;

endpackage

// ===== design/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] pin_raw,
  output logic      [W-1:0] pin_clean
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] clean;
  } sync_t;

  sync_t st_ff;
  sync_t nxt_st;

  // a bit moves only once stages two and three agree; stage one feeds stage two only
  always_comb
  begin
    nxt_st       = st_ff;
    nxt_st.s1    = pin_raw;
    nxt_st.s2    = st_ff.s1;
    nxt_st.s3    = st_ff.s2;
    nxt_st.clean = (~(st_ff.s2 ^ st_ff.s3) & st_ff.s3) | ((st_ff.s2 ^ st_ff.s3) & st_ff.clean);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign pin_clean = st_ff.clean;
endmodule // pin_sync

// ===== tb/burner_model.sv
`timescale 1ns/10ps
module burner_model
  import ignition_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire drive_t burner,
  input  wire logic   no_flame,
  output logic        pressure_sw_pin,
  output logic        flame_sense_pin
);
  logic [3:0] lag_ff = 4'h0;
  initial pressure_sw_pin = 1'b0;
  initial flame_sense_pin = 1'b0;
  // switch closes a few cycles after the fan spins up; flame holds while gas stays on and no_flame is low
  always @(posedge sys_clk)
  begin
    lag_ff <= {lag_ff[2:0], burner.inducer};
    pressure_sw_pin <= lag_ff[3];
    flame_sense_pin <= burner.gas & ~no_flame & (burner.igniter | flame_sense_pin);
  end
endmodule // burner_model

// ===== tb/boiler_ignition_sequencer_bench.sv
`timescale 1ns/10ps
module boiler_ignition_sequencer_bench;
  import ignition_pkg::*;
  logic              sys_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              heat = 1'b0, up = 1'b0, dn = 1'b0, item = 1'b0, no_flame = 1'b0;
  logic              lclr = 1'b0, odv = 1'b1;
  logic              pres, flame, adj;
  logic signed [8:0] wtemp = 9'h064;
  drive_t            burner;
  disp_t             disp;
  logic [4:0]        phase;
  logic [7:0]        err;
  logic [8:0]        cut, hyst, odmax, odmin, pfloor, pcap;
  int                bad_count = 0;
  int                samples_checked = 0;
  // short tick and hold so the run stays brief
  boiler_ignition_sequencer #(.TICK_CLKS(10), .HOLD_CLKS(30)) DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .heat_call_pin(heat), .pressure_sw_pin(pres),
    .flame_sense_pin(flame), .btn_up_pin(up), .btn_down_pin(dn), .btn_item_pin(item),
    .lockout_clear_pin(lclr), .water_temp(wtemp), .operating_target(9'h0B4),
    .ionization_level(8'h20), .outdoor_valid(odv), .nv_lock_in(1'b0), .burner(burner),
    .phase_readout(phase), .error_code(err), .display(disp), .adjust_mode(adj),
    .upper_temp_cutout(cut), .cutout_hysteresis(hyst), .outdoor_design_max(odmax),
    .outdoor_design_min(odmin), .purge_floor_temp(pfloor), .purge_time_cap(pcap));
  burner_model far_side (.sys_clk(sys_clk), .burner(burner), .no_flame(no_flame),
    .pressure_sw_pin(pres), .flame_sense_pin(flame));
  always #5 sys_clk = ~sys_clk;
  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // bounded poll for a readout code
  task automatic wait_phase(input logic [4:0] code, input int lim);
    int n;
    n = 0;
    while (phase !== code && n < lim)
    begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  // press and release item; the gap covers sync delay plus the label register
  task automatic pulse_item(input int n);
    repeat (n)
    begin
      item <= 1'b1;
      repeat (6) @(posedge sys_clk);
      item <= 1'b0;
      repeat (8) @(posedge sys_clk);
    end
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic t_defaults();
    check(cut, 12'h0B4, "cutout");
    check(hyst, 12'h00F, "hyst");
    check(pfloor, 12'h08C, "floor");
    check(pcap, 12'h002, "cap");
    check(disp.unit, UN_NONE, "unit");
    check(phase, 12'h001, "idle");
    $display("test defaults done");
  endtask
  task automatic t_fire();
    heat <= 1'b1;
    wait_phase(5'h02, 20);
    check(burner.inducer, 1'b0, "fan off");
    wait_phase(5'h03, 20);
    @(posedge sys_clk);
    check(burner.inducer, 1'b1, "fan on");
    wait_phase(5'h04, 30);
    wait (burner.relay_test === 1'b1 || phase !== 5'h04);
    check(phase, 12'h004, "relay test in purge");
    wait_phase(5'h06, 60);
    check({burner.gas, burner.igniter}, 12'h003, "spark");
    wait_phase(5'h07, 200);
    check(burner.igniter, 1'b0, "prove");
    wait_phase(5'h08, 40);
    check(phase, 12'h008, "run");
    no_flame <= 1'b1;
    wait_phase(5'h0A, 20);
    check({phase, burner.gas}, 12'h014, "flame loss");
    heat <= 1'b0;
    no_flame <= 1'b0;
    wait_phase(5'h01, 20);
    $display("test firing done");
  endtask
  task automatic t_lockout();
    do_reset();
    no_flame <= 1'b1;
    heat <= 1'b1;
    wait_phase(5'h0D, 3000);
    check({phase, err}, 12'hD3E, "soft lock");
    heat <= 1'b0;
    no_flame <= 1'b0;
    lclr <= 1'b1;
    wait_phase(5'h01, 20);
    lclr <= 1'b0;
    check(err, 12'h000, "cleared");
    do_reset();
    $display("test lockout done");
  endtask
  task automatic t_hot();
    wtemp <= 9'h0C8;
    heat <= 1'b1;
    repeat (20) @(posedge sys_clk);
    check({phase, burner.circ, burner.inducer}, 12'h006, "circ only");
    wtemp <= 9'h0A5;
    repeat (5) @(posedge sys_clk);
    check(burner.inducer, 1'b0, "hold off");
    wtemp <= 9'h0A4;
    wait_phase(5'h03, 10);
    check(burner.inducer, 1'b1, "relight");
    heat <= 1'b0;
    repeat (300) @(posedge sys_clk);
    check(burner.circ, 1'b1, "overrun");
    repeat (400) @(posedge sys_clk);
    check(burner.circ, 1'b0, "pump off");
    wtemp <= 9'h064;
    $display("test hot water done");
  endtask
  task automatic t_adjust();
    {up, dn, item} <= 3'h7;
    repeat (45) @(posedge sys_clk);
    check(adj, 1'b1, "enter");
    {up, dn, item} <= 3'h0;
    repeat (10) @(posedge sys_clk);
    up <= 1'b1;
    repeat (10) @(posedge sys_clk);
    up <= 1'b0;
    repeat (10) @(posedge sys_clk);
    check(cut, 12'h0B5, "raise");
    check(disp.unit, UN_F, "unit F");
    check(disp.value, 12'h0B5, "value");
    pulse_item(3);
    check(disp.label, 12'h013, "item 3");
    dn <= 1'b1;
    repeat (10) @(posedge sys_clk);
    dn <= 1'b0;
    repeat (10) @(posedge sys_clk);
    check(odmax, 12'h036, "lower");
    pulse_item(3);
    check(disp.label, 12'h018, "skip purge");
    odv <= 1'b0;
    pulse_item(8);
    check(disp.label, 12'h016, "purge item");
    repeat (650) @(posedge sys_clk);
    check(adj, 1'b0, "quiet exit");
    $display("test adjust done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    do_reset();
    t_defaults();
    t_fire();
    t_lockout();
    t_hot();
    t_adjust();
    report_and_stop();
  end
  // whole run needs well under fifteen thousand cycles
  initial
  begin
    #500000;
    bad_count++;
    report_and_stop();
  end
endmodule // boiler_ignition_sequencer_bench
